// ### common/act_params.svh
// Constants for the asynchronous-capable 16-bit counter/timer
`ifndef ACT_PARAMS_SVH
`define ACT_PARAMS_SVH

// Control register layout and reset value
`define ACT_CTRL_RESET 8'h00
`define ACT_CTRL_USED_MASK 8'h3F
// Compare unit mode that issues the special event trigger
`define ACT_MODE_SPECIAL 4'hB
// Count values
`define ACT_CNT_CLEAR 16'h0000
`define ACT_CNT_ALL_ONES 16'hFFFF
`define ACT_CNT_ONE 16'h0001
// Instruction clock is the system clock divided by four
`define ACT_CLK_PERIOD_NS 10
`define ACT_INSTR_PERIOD_NS 40
`define ACT_INSTR_DIV_LAST 2'((`ACT_INSTR_PERIOD_NS / `ACT_CLK_PERIOD_NS) - 1)
`define ACT_DIV_ZERO 2'h0
`define ACT_DIV_ONE 2'h1
// Prescaler counter
`define ACT_PRE_ZERO 3'h0
`define ACT_PRE_ONE 3'h1
// Synchroniser delay in the synchronised counter path
`define ACT_SYNC_ZERO 2'h0
// Oscillator rating, for reference by users of the block
`define ACT_OSC_MAX_KHZ 200

`endif

// ### common/act_pkg.sv
// Types shared by the counter/timer design
package act_pkg;

    // Counter control register fields
    typedef struct packed {
        logic [1:0] unused;
        logic [1:0] prescale;
        logic low_power_osc_enable;
        logic ext_clock_sync_disable;
        logic clock_source_select;
        logic counter_on_bit;
    } act_ctrl_type;

    // Operating mode of the counter
    typedef enum logic [1:0] {
        ACT_TIMER = 2'b00,
        ACT_SYNC_COUNT = 2'b01,
        ACT_ASYNC_COUNT = 2'b10
    } act_mode_type;

    // Special event trigger from one compare unit
    typedef struct packed {
        logic trigger;
        logic [3:0] compare_unit_mode_field;
    } act_trig_type;

endpackage

// ### hw/act_rise_det.sv
// Rising edge detector for a sampled input level
`timescale 1ns/100ps
module act_rise_det (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic level,
    output logic rise
);
    logic prev;
    logic next_prev;

    // Remember the previous level
    always_comb begin
        next_prev = level;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev <= 1'b0;
        end else begin
            prev <= next_prev;
        end
    end

    // One-cycle pulse on a low to high change
    assign rise = level && !prev;
endmodule

// ### hw/act_counter_timer.sv
// 16-bit counter/timer with synchronised and asynchronous count modes
// Notes on behaviour
// - Sync-disable set: external edges count without synchroniser delay.
// - Asynchronous count keeps running in sleep; overflow flag can wake processor.
// - In asynchronous count mode the count is no capture/compare time base.
// - Count bytes read valid at all times while counting externally.
// - Control bit 3 enables the built-in crystal oscillator.
// - Oscillator is low power, up to 200 kHz, running through sleep.
// - Special event trigger from a compare unit in mode 1011 clears count.
// - Trigger clear never sets the overflow flag.
// - Trigger clear only guaranteed in timer or synchronised counter mode.
// - Count write in same cycle as trigger wins over the trigger.
// - With trigger clear, compare value pair acts as period register.
// - Count bytes keep value over all resets; only triggers, count writes and overflow wrap clear them.
// - Control register clears to 00h on every reset (RST_N low).
// - Writing either count byte clears the prescaler.
// - Counter mode counts oscillator pin edges when enabled, else clock pin.
`timescale 1ns/100ps
`include "act_params.svh"
module act_counter_timer (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic SLEEP,
    input wire logic CTRL_WR,
    input wire logic [7:0] CTRL_WDATA,
    output logic [7:0] CTRL_RDATA,
    input wire logic CNT_WR_LOW,
    input wire logic CNT_WR_HIGH,
    input wire logic [7:0] CNT_WDATA,
    output logic [7:0] CNT_LOW,
    output logic [7:0] CNT_HIGH,
    input wire logic OSC_IN_PIN,
    input wire logic EXT_CLK_PIN,
    output logic OSC_AMP_EN,
    input wire act_pkg::act_trig_type TRIG_A,
    input wire act_pkg::act_trig_type TRIG_B,
    output logic TIMEBASE_OK,
    input wire logic OVF_CLR,
    output logic OVF_FLAG,
    output logic WAKE_REQ
);
    act_pkg::act_ctrl_type ctrl;
    act_pkg::act_ctrl_type next_ctrl;
    act_pkg::act_mode_type mode;
    logic [15:0] count;
    logic [15:0] next_count;
    logic [2:0] pre;
    logic [2:0] next_pre;
    logic [2:0] pre_mask;
    logic [1:0] div;
    logic [1:0] next_div;
    logic [1:0] sync_pipe;
    logic [1:0] next_sync_pipe;
    logic ovf;
    logic next_ovf;
    logic instr_en;
    logic pin_level;
    logic pin_rise;
    logic raw_tick;
    logic pre_tick;
    logic inc;
    logic any_wr;
    logic trig_hit;
    logic ovf_set;

    // Control register, cleared by every reset (RST_N low)
    always_comb begin
        next_ctrl = ctrl;
        if (CTRL_WR) begin
            next_ctrl = act_pkg::act_ctrl_type'(CTRL_WDATA & `ACT_CTRL_USED_MASK);
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl <= act_pkg::act_ctrl_type'(`ACT_CTRL_RESET);
        end else begin
            ctrl <= next_ctrl;
        end
    end

    // Mode decode from the control fields
    always_comb begin
        if (!ctrl.clock_source_select) begin
            mode = act_pkg::ACT_TIMER;
        end else if (ctrl.ext_clock_sync_disable) begin
            mode = act_pkg::ACT_ASYNC_COUNT;
        end else begin
            mode = act_pkg::ACT_SYNC_COUNT;
        end
    end

    assign OSC_AMP_EN = ctrl.low_power_osc_enable;
    assign TIMEBASE_OK = (mode != act_pkg::ACT_ASYNC_COUNT);
    assign CTRL_RDATA = ctrl;

    assign pin_level = ctrl.low_power_osc_enable ? OSC_IN_PIN : EXT_CLK_PIN;

    act_rise_det u_pin_edge (
        .clk(CLK),
        .rst_n(RST_N),
        .level(pin_level),
        .rise(pin_rise)
    );

    // Instruction clock divider; it halts in sleep like the core clock
    always_comb begin
        next_div = div + `ACT_DIV_ONE;
        if (SLEEP) begin
            next_div = div;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            div <= `ACT_DIV_ZERO;
        end else begin
            div <= next_div;
        end
    end

    assign instr_en = (div == `ACT_INSTR_DIV_LAST) && !SLEEP;

    // Prescaler input: pin edges in counter mode, instruction clock otherwise
    assign raw_tick = ctrl.counter_on_bit && (ctrl.clock_source_select ? pin_rise : instr_en);
    assign any_wr = CNT_WR_LOW || CNT_WR_HIGH;

    // Prescale mask for 1:1, 1:2, 1:4, 1:8
    always_comb begin
        unique case (ctrl.prescale)
            2'h0: pre_mask = 3'h0;
            2'h1: pre_mask = 3'h1;
            2'h2: pre_mask = 3'h3;
            2'h3: pre_mask = 3'h7;
        endcase
    end

    assign pre_tick = raw_tick && ((pre & pre_mask) == pre_mask);

    // Prescaler counter
    always_comb begin
        next_pre = pre;
        if (any_wr) begin
            next_pre = `ACT_PRE_ZERO;
        end else if (raw_tick) begin
            next_pre = pre_tick ? `ACT_PRE_ZERO : pre + `ACT_PRE_ONE;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pre <= `ACT_PRE_ZERO;
        end else begin
            pre <= next_pre;
        end
    end

    // Synchroniser stages after the prescaler, output masked off during sleep
    always_comb begin
        next_sync_pipe = {sync_pipe[0], pre_tick && (mode == act_pkg::ACT_SYNC_COUNT)};
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sync_pipe <= `ACT_SYNC_ZERO;
        end else begin
            sync_pipe <= next_sync_pipe;
        end
    end

    assign inc = (pre_tick && (mode != act_pkg::ACT_SYNC_COUNT)) || (sync_pipe[1] && !SLEEP);

    assign trig_hit = ((TRIG_A.trigger && (TRIG_A.compare_unit_mode_field == `ACT_MODE_SPECIAL))
                    || (TRIG_B.trigger && (TRIG_B.compare_unit_mode_field == `ACT_MODE_SPECIAL)))
                    && (mode != act_pkg::ACT_ASYNC_COUNT);

    assign ovf_set = inc && !any_wr && !trig_hit && (count == `ACT_CNT_ALL_ONES);

    // Count register update
    always_comb begin
        next_count = count;
        if (any_wr) begin
            if (CNT_WR_LOW) begin
                next_count[7:0] = CNT_WDATA;
            end
            if (CNT_WR_HIGH) begin
                next_count[15:8] = CNT_WDATA;
            end
        end else if (trig_hit) begin
            next_count = `ACT_CNT_CLEAR;
        end else if (inc) begin
            next_count = count + `ACT_CNT_ONE;
        end
    end

    always_ff @(posedge CLK) begin
        count <= next_count;
    end

    // read bytes come straight from the count flops
    assign CNT_LOW = count[7:0];
    assign CNT_HIGH = count[15:8];

    // Overflow flag, set beats clear
    always_comb begin
        next_ovf = (ovf && !OVF_CLR) || ovf_set;
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ovf <= 1'b0;
        end else begin
            ovf <= next_ovf;
        end
    end

    assign OVF_FLAG = ovf;
    assign WAKE_REQ = ovf && SLEEP;

    chk_async_direct: assert property (@(posedge CLK) disable iff (!RST_N)
        (mode == act_pkg::ACT_ASYNC_COUNT && pre_tick && !any_wr) |=> (count == $past(count) + `ACT_CNT_ONE))
        else $error("async tick did not increment next cycle");

    chk_sleep_runs: assert property (@(posedge CLK) disable iff (!RST_N)
        (SLEEP && mode == act_pkg::ACT_ASYNC_COUNT && pre_tick && !any_wr && count == `ACT_CNT_ALL_ONES)
        |=> (OVF_FLAG && WAKE_REQ || !SLEEP))
        else $error("async overflow in sleep gave no wake");

    chk_no_timebase: assert property (@(posedge CLK) disable iff (!RST_N)
        ctrl.clock_source_select && ctrl.ext_clock_sync_disable |-> !TIMEBASE_OK)
        else $error("async mode offered as time base");

    chk_read_stable: assert property (@(posedge CLK) disable iff (!RST_N)
        (!any_wr && !trig_hit && !inc) |=> $stable({CNT_HIGH, CNT_LOW}))
        else $error("count bytes changed without cause");

    chk_osc_sleep: assert property (@(posedge CLK) disable iff (!RST_N)
        (OSC_AMP_EN && SLEEP && !CTRL_WR) |=> OSC_AMP_EN)
        else $error("oscillator stopped in sleep");

    chk_trig_clear: assert property (@(posedge CLK) disable iff (!RST_N)
        (TRIG_A.trigger && TRIG_A.compare_unit_mode_field == `ACT_MODE_SPECIAL && !any_wr
         && mode != act_pkg::ACT_ASYNC_COUNT) |=> ({CNT_HIGH, CNT_LOW} == `ACT_CNT_CLEAR))
        else $error("trigger did not clear count");

    chk_trig_noflag: assert property (@(posedge CLK) disable iff (!RST_N)
        (trig_hit && !OVF_FLAG) |=> !OVF_FLAG)
        else $error("trigger set overflow flag");

    chk_write_wins: assert property (@(posedge CLK) disable iff (!RST_N)
        (CNT_WR_LOW && trig_hit) |=> (CNT_LOW == $past(CNT_WDATA)))
        else $error("trigger beat count write");

    chk_ctrl_write: assert property (@(posedge CLK) disable iff (!RST_N)
        CTRL_WR |=> (CTRL_RDATA == ($past(CTRL_WDATA) & `ACT_CTRL_USED_MASK)))
        else $error("control write not stored");

    chk_pre_clear: assert property (@(posedge CLK) disable iff (!RST_N)
        any_wr |=> (pre == `ACT_PRE_ZERO))
        else $error("prescaler not cleared by write");

    chk_wrap_flag: assert property (@(posedge CLK) disable iff (!RST_N)
        ovf_set |=> (OVF_FLAG && count == `ACT_CNT_CLEAR))
        else $error("wrap did not set flag");
endmodule

// ### verification/act_pin_src.sv
// Model of the external clock source or crystal driving the counter pins
`timescale 1ns/100ps
module act_pin_src #(
    parameter int HALF = 250
) (
    input wire logic clk,
    input wire logic start,
    input wire logic sel_osc,
    input wire logic [7:0] n,
    output logic busy,
    output logic osc_pin,
    output logic ext_pin
);
    logic [7:0] left = 8'h00;
    logic [9:0] ph = 10'h000;
    logic lvl;
    initial busy = 1'b0;
    // rate limit: a half period of 250 cycles keeps the source at 200 kHz
    always @(posedge clk) begin
        if (start && !busy) begin
            busy <= #1 1'b1;
            left <= #1 n;
            ph <= #1 10'h000;
        end else if (busy) begin
            ph <= #1 (ph == 10'(2 * HALF - 1)) ? 10'h000 : ph + 10'h001;
            if (ph == 10'(2 * HALF - 1)) begin
                left <= #1 left - 8'h01;
                busy <= #1 (left != 8'h01);
            end
        end
    end
    // Pins stand low outside a burst; only the chosen pin toggles
    assign lvl = busy && (ph < 10'(HALF));
    assign osc_pin = lvl & sel_osc;
    assign ext_pin = lvl & !sel_osc;
endmodule

// ### verification/act_counter_timer_bench.sv
// Self-checking bench for the 16-bit counter/timer
`timescale 1ns/100ps
module act_counter_timer_bench;
    logic CLK = 0, RST_N = 0, SLEEP = 0, CTRL_WR = 0, CNT_WR_LOW = 0, CNT_WR_HIGH = 0, OVF_CLR = 0;
    logic [7:0] CTRL_WDATA = 8'h00, CNT_WDATA = 8'h00, CTRL_RDATA, CNT_LOW, CNT_HIGH, n = 8'h01, v;
    logic OSC_IN_PIN, EXT_CLK_PIN, OSC_AMP_EN, TIMEBASE_OK, OVF_FLAG, WAKE_REQ, start = 0, sel_osc = 0, busy;
    act_pkg::act_trig_type TRIG_A = '0, TRIG_B = '0;
    int err_count = 0, cmp_count = 0;
    logic [15:0] c;
    always #5 CLK = ~CLK;
    act_counter_timer dut (.CLK(CLK), .RST_N(RST_N), .SLEEP(SLEEP), .CTRL_WR(CTRL_WR), .CTRL_WDATA(CTRL_WDATA),
        .CTRL_RDATA(CTRL_RDATA), .CNT_WR_LOW(CNT_WR_LOW), .CNT_WR_HIGH(CNT_WR_HIGH), .CNT_WDATA(CNT_WDATA),
        .CNT_LOW(CNT_LOW), .CNT_HIGH(CNT_HIGH), .OSC_IN_PIN(OSC_IN_PIN), .EXT_CLK_PIN(EXT_CLK_PIN),
        .OSC_AMP_EN(OSC_AMP_EN), .TRIG_A(TRIG_A), .TRIG_B(TRIG_B), .TIMEBASE_OK(TIMEBASE_OK),
        .OVF_CLR(OVF_CLR), .OVF_FLAG(OVF_FLAG), .WAKE_REQ(WAKE_REQ));
    act_pin_src src (.clk(CLK), .start(start), .sel_osc(sel_osc), .n(n), .busy(busy),
        .osc_pin(OSC_IN_PIN), .ext_pin(EXT_CLK_PIN));
    // Expected control readback and prescaled count
    function automatic logic [7:0] exp_ctrl(input logic [7:0] d);
        return d & 8'h3F;
    endfunction
    function automatic logic [15:0] exp_cnt(input logic [15:0] base, input int edges, input int ps);
        return base + 16'(edges >> ps);
    endfunction
    task automatic tick(input int k);
        repeat (k) @(posedge CLK);
        #1;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("Compares %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wr_ctrl(input logic [7:0] d);
        CTRL_WR = 1;
        CTRL_WDATA = d;
        tick(1);
        CTRL_WR = 0;
        tick(1);
    endtask
    // Counter is stopped by the caller before this, so no write contention
    task automatic wr_cnt(input logic [15:0] d);
        CNT_WR_HIGH = 1;
        CNT_WDATA = d[15:8];
        tick(1);
        CNT_WR_HIGH = 0;
        CNT_WR_LOW = 1;
        CNT_WDATA = d[7:0];
        tick(1);
        CNT_WR_LOW = 0;
        tick(1);
    endtask
    // Ask the source for k rising edges and wait, bounded, for the burst
    task automatic pulse(input logic osc, input logic [7:0] k);
        int i;
        sel_osc = osc;
        n = k;
        start = 1;
        tick(2);
        start = 0;
        for (i = 0; i < 6000 && busy === 1'b1; i++) tick(1);
        if (i == 6000) begin
            err_count++;
            report_and_stop();
        end
        tick(4);
    endtask
    task automatic trig(input logic b, input logic [3:0] m);
        if (b) TRIG_B = {1'b1, m};
        else TRIG_A = {1'b1, m};
        tick(1);
        TRIG_A = '0;
        TRIG_B = '0;
        tick(1);
    endtask
    initial begin
        c = 16'($urandom(45));
        // Count has no reset, so give it a known value while reset is held
        wr_cnt(c);
        check(CTRL_RDATA, 8'h00);
        check(OVF_FLAG, 1'b0);
        check({CNT_HIGH, CNT_LOW}, c);
        RST_N = 1;
        for (int i = 0; i < 6; i++) begin
            v = $urandom;
            wr_ctrl(v);
            check(CTRL_RDATA, exp_ctrl(v));
            check(OSC_AMP_EN, v[3]);
            check(TIMEBASE_OK, !(v[1] & v[2]));
        end
        // stop first: count survives a mid-run reset, control clears
        wr_ctrl(8'h00);
        c = $urandom;
        wr_cnt(c);
        wr_ctrl(8'h34);
        RST_N = 0;
        tick(2);
        RST_N = 1;
        tick(1);
        check(CTRL_RDATA, 8'h00);
        check({CNT_HIGH, CNT_LOW}, c);
        // Asynchronous external count in sleep wraps and wakes
        wr_cnt(16'hFFFE);
        wr_ctrl(8'h07);
        SLEEP = 1;
        pulse(0, 8'h02);
        check({CNT_HIGH, CNT_LOW}, 16'h0000);
        check(WAKE_REQ, 1'b1);
        SLEEP = 0;
        OVF_CLR = 1;
        tick(1);
        OVF_CLR = 0;
        tick(1);
        check(OVF_FLAG, 1'b0);
        // Trigger clear is dependable in timer mode
        wr_ctrl(8'h00);
        wr_cnt(16'hA5A5);
        wr_ctrl(8'h01);
        trig(0, 4'hB);
        check(CNT_HIGH, 8'h00);
        // start-up delay: oscillator pin source, timed by software
        wr_ctrl(8'h00);
        c = 16'($urandom) & 16'h7FFF;
        wr_cnt(c);
        wr_ctrl(8'h0F);
        tick(20);
        v = 8'(1 + $urandom % 8);
        pulse(1, v);
        check({CNT_HIGH, CNT_LOW}, exp_cnt(c, v, 0));
        pulse(0, 8'h03);
        check({CNT_HIGH, CNT_LOW}, exp_cnt(c, v, 0));
        trig(0, 4'hB);
        check({CNT_HIGH, CNT_LOW}, exp_cnt(c, v, 0));
        // Synchronised count with 1:4 prescale, cleared by a count write
        wr_ctrl(8'h00);
        wr_cnt(16'h0000);
        wr_ctrl(8'h23);
        pulse(0, 8'h02);
        wr_ctrl(8'h22);
        wr_cnt(16'h0000);
        wr_ctrl(8'h23);
        pulse(0, 8'h03);
        check({CNT_HIGH, CNT_LOW}, 16'h0000);
        pulse(0, 8'h05);
        check({CNT_HIGH, CNT_LOW}, exp_cnt(16'h0000, 8, 2));
        // Every mode code on both compare units, counter stopped
        wr_ctrl(8'h22);
        for (int m = 0; m < 32; m++) begin
            c = 16'($urandom) | 16'h0001;
            wr_cnt(c);
            trig(m[4], m[3:0]);
            check({CNT_HIGH, CNT_LOW}, (m[3:0] == 4'hB) ? 16'h0000 : c);
            check(OVF_FLAG, 1'b0);
        end
        // Count write coinciding with a trigger keeps the written byte
        v = $urandom;
        CNT_WR_LOW = 1;
        CNT_WDATA = v;
        trig(1, 4'hB);
        CNT_WR_LOW = 0;
        check(CNT_LOW, v);
        report_and_stop();
    end
endmodule
